/* hw/asc_map.svh */
// Purpose: Register offsets, bit positions, reset values and timing
// Assumes: Included by bare name from package and modules
// Notes:   Definitions only
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// Register offsets (word index on the register port)
`define ASC_OFS_MODE0      3'h0
`define ASC_OFS_MODE1      3'h1
`define ASC_OFS_RESULT     3'h2
`define ASC_OFS_PINSEL     3'h3
`define ASC_OFS_DIR        3'h4
`define ASC_OFS_PENABLE    3'h5
`define ASC_OFS_STATUS     3'h6
`define ASC_OFS_MASK       3'h7

// Bit positions
`define ASC_B_START        7
`define ASC_B_CHMODE       6
`define ASC_B_COMPARATOR   0
`define ASC_B_TRIG_HI      7
`define ASC_B_TRIG_LO      6
`define ASC_B_ONESHOT      5
`define ASC_B_CLKGATE      5
`define ASC_B_PIN20        0
`define ASC_B_EOC          0

// Field limits and codes
`define ASC_PIN_MAXCODE    4'h3
`define ASC_PIN_ALL        4'h0
`define ASC_PIN_NONE       4'h1
`define ASC_PIN_CH0        4'h2
`define ASC_PIN_CH01       4'h3
`define ASC_MODE1_MASK     8'hE3
`define ASC_RES_PAD        6'h00

// Reset values
`define ASC_RST_MODE       8'h00
`define ASC_RST_PINSEL     4'h0
`define ASC_RST_DIR        8'hFF
`define ASC_RST_PENABLE    8'h00
`define ASC_RST_RESULT     10'h000
`define ASC_RST_RDATA      16'h0000
`define ASC_RST_CNT        8'h00

// Conversion time
`define ASC_CNT_W          8
`define ASC_CLK_PERIOD_NS  4
`define ASC_CONV_TIME_NS   1000
`define ASC_CONV_CYCLES    (`ASC_CONV_TIME_NS / `ASC_CLK_PERIOD_NS)

`endif

/* hw/asc_pkg.sv */
// Purpose: Types for the converter control block
// Assumes: asc_map.svh supplies widths
// Notes:   State of each module is one packed struct
`include "asc_map.svh"
package asc_pkg;

  typedef enum logic [0:0] {ST_IDLE, ST_CONV} asc_state_e;

  typedef struct packed {
    asc_state_e  st;
    logic [7:0]  mode0;
    logic [7:0]  mode1;
    logic [9:0]  result;
    logic [3:0]  pinsel;
    logic [7:0]  dir;
    logic [7:0]  penable;
    logic        status;
    logic        mask;
    logic [15:0] rdata;
  } asc_ctrl_s;

  typedef struct packed {
    logic [`ASC_CNT_W-1:0] cnt;
  } asc_tmr_s;

endpackage

/* hw/asc_conv_timer.sv */
// Purpose: Counts one conversion time and pulses done at its end
// Assumes: run held high for the whole conversion
// Notes:   Counter clears whenever run drops
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_conv_timer
  import asc_pkg::*;
#(
  parameter logic [`ASC_CNT_W-1:0] LAST = `ASC_CNT_W'(`ASC_CONV_CYCLES - 1)
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Control
  input  wire logic run,
  output logic      done
);

  asc_tmr_s s_reg;
  asc_tmr_s s_next;

  assign done = run && (s_reg.cnt == LAST);

  always_comb
  begin
    s_next = s_reg;
    if (!run || done)
    begin
      s_next.cnt = `ASC_RST_CNT;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + `ASC_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg.cnt <= `ASC_RST_CNT;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

/* hw/asc_ctrl.sv */
// Purpose: Software-triggered converter control with result and interrupt
// Assumes: Register port one cycle read latency; sample input is stable
// Notes:   Hardware trigger sources are not built in
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_ctrl
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Analog front end
  input  wire logic [9:0]  adc_sample,
  output logic             conv_clk_en,
  output logic             channel_scan,
  output logic      [14:0] analog_pin_en,
  // Port 2 pin 0 buffer
  output logic             port20_oe,
  // Interrupt
  output logic             conv_end_irq
);

  asc_ctrl_s s_reg;
  asc_ctrl_s s_next;
  logic      run;
  logic      done;
  logic      wr0;

  assign wr0 = reg_wr && (reg_addr == `ASC_OFS_MODE0);
  // Conversion may run only with clock, comparator and software trigger
  assign run = s_reg.mode0[`ASC_B_START]
            && s_reg.penable[`ASC_B_CLKGATE]
            && s_reg.mode0[`ASC_B_COMPARATOR]
            && !s_reg.mode1[`ASC_B_TRIG_HI];

  asc_conv_timer u_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (run && (s_reg.st == ST_CONV)),
    .done    (done)
  );

  assign reg_rdata    = s_reg.rdata;
  assign conv_clk_en  = s_reg.penable[`ASC_B_CLKGATE];
  assign channel_scan = s_reg.mode0[`ASC_B_CHMODE];
  assign port20_oe    = !s_reg.dir[`ASC_B_PIN20];
  // Level irq; also the halt wake request
  assign conv_end_irq = s_reg.status && s_reg.mask;

  always_comb
  begin
    unique case (s_reg.pinsel)
      `ASC_PIN_ALL:  analog_pin_en = 15'h7FFF;
      `ASC_PIN_CH0:  analog_pin_en = 15'h0001;
      `ASC_PIN_CH01: analog_pin_en = 15'h0003;
      default:       analog_pin_en = 15'h0000;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = `ASC_RST_RDATA;
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `ASC_OFS_MODE0:   s_next.mode0 = reg_wdata[7:0];
        `ASC_OFS_MODE1:   s_next.mode1 = reg_wdata[7:0] & `ASC_MODE1_MASK;
        `ASC_OFS_PINSEL:
        begin
          if (reg_wdata[7:0] <= {4'h0, `ASC_PIN_MAXCODE})
          begin
            s_next.pinsel = reg_wdata[3:0];
          end
        end
        `ASC_OFS_DIR:     s_next.dir = reg_wdata[7:0];
        `ASC_OFS_PENABLE: s_next.penable = reg_wdata[7:0];
        `ASC_OFS_MASK:    s_next.mask = reg_wdata[`ASC_B_EOC];
        default:          s_next.mode0 = s_reg.mode0;
      endcase
    end
    // Register reads; status clears on read
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ASC_OFS_MODE0:   s_next.rdata = {8'h00, s_reg.mode0};
        `ASC_OFS_MODE1:   s_next.rdata = {8'h00, s_reg.mode1};
        `ASC_OFS_RESULT:  s_next.rdata = {s_reg.result, `ASC_RES_PAD};
        `ASC_OFS_PINSEL:  s_next.rdata = {12'h000, s_reg.pinsel};
        `ASC_OFS_DIR:     s_next.rdata = {8'h00, s_reg.dir};
        `ASC_OFS_PENABLE: s_next.rdata = {8'h00, s_reg.penable};
        `ASC_OFS_STATUS:
        begin
          s_next.rdata  = {15'h0000, s_reg.status};
          s_next.status = 1'b0;
        end
        `ASC_OFS_MASK:    s_next.rdata = {15'h0000, s_reg.mask};
        default:          s_next.rdata = `ASC_RST_RDATA;
      endcase
    end
    // Conversion sequencing
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (run)
        begin
          s_next.st = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (!run)
        begin
          s_next.st = ST_IDLE;
        end
        else if (done)
        begin
          s_next.result = adc_sample;
          s_next.status = 1'b1;
          if (s_reg.mode1[`ASC_B_ONESHOT])
          begin
            s_next.st = ST_IDLE;
            if (!(wr0 && reg_wdata[`ASC_B_START]))
            begin
              s_next.mode0[`ASC_B_START] = 1'b0;
            end
          end
          else
          begin
            s_next.st = ST_CONV;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg.st      <= ST_IDLE;
      s_reg.mode0   <= `ASC_RST_MODE;
      s_reg.mode1   <= `ASC_RST_MODE;
      s_reg.result  <= `ASC_RST_RESULT;
      s_reg.pinsel  <= `ASC_RST_PINSEL;
      s_reg.dir     <= `ASC_RST_DIR;
      s_reg.penable <= `ASC_RST_PENABLE;
      s_reg.status  <= 1'b0;
      s_reg.mask    <= 1'b0;
      s_reg.rdata   <= `ASC_RST_RDATA;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  a_start_conv: assert property (@(posedge sys_clk) disable iff (!resetn)
    (s_reg.st == ST_IDLE && run) |=> s_reg.st == ST_CONV)
    else $error("start did not begin a conversion");

  a_result_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    done |=> s_reg.result == $past(adc_sample) && s_reg.status)
    else $error("result or status not loaded at end");

  a_irq_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    (done && s_reg.mask && !(reg_wr && reg_addr == `ASC_OFS_MASK))
      |=> conv_end_irq)
    else $error("end interrupt missing");

  a_pin_upper: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reg_rd && reg_addr == `ASC_OFS_PINSEL) |=> reg_rdata[15:4] == 12'h000)
    else $error("pin select upper bits not zero");

  a_pin_prohib: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reg_wr && reg_addr == `ASC_OFS_PINSEL
      && reg_wdata[7:0] > {4'h0, `ASC_PIN_MAXCODE})
      |=> $stable(s_reg.pinsel))
    else $error("prohibited pin code accepted");

  a_dir_buffer: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reg_wr && reg_addr == `ASC_OFS_DIR)
      |=> port20_oe == !$past(reg_wdata[`ASC_B_PIN20]))
    else $error("pin 20 buffer does not follow direction");

  a_clock_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    !conv_clk_en |-> !done ##1 s_reg.st == ST_IDLE || conv_clk_en)
    else $error("conversion ran with clock stopped");

  a_scan_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr0 |=> channel_scan == $past(reg_wdata[`ASC_B_CHMODE]))
    else $error("channel mode not taken");

  a_one_shot: assert property (@(posedge sys_clk) disable iff (!resetn)
    (done && s_reg.mode1[`ASC_B_ONESHOT] && !wr0)
      |=> !s_reg.mode0[`ASC_B_START] && s_reg.st == ST_IDLE)
    else $error("one-shot did not stop");

  a_hw_trig: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg.mode1[`ASC_B_TRIG_HI] |-> !done)
    else $error("software start ran in hardware trigger mode");

  a_sequential: assert property (@(posedge sys_clk) disable iff (!resetn)
    (done && !s_reg.mode1[`ASC_B_ONESHOT])
      |=> s_reg.st == ST_CONV && s_reg.mode0[`ASC_B_START]
      || $past(reg_wr))
    else $error("sequential mode did not restart");

endmodule

/* test/tb_adc_soft_trigger_control.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Four-state compares, register port one-cycle read latency
// Notes:   Reset outputs first, then table of register cases, conversions and a mid-run reset
`timescale 1ns/1ns
`include "asc_map.svh"
module tb_adc_soft_trigger_control;
  typedef struct {
    logic [2:0]  a;
    logic [15:0] w;
    logic [15:0] r;
    logic [14:0] pin;
    logic [2:0]  ctl;
  } asc_row_s;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [9:0]  adc_sample = 10'h2AB;
  logic [15:0] reg_rdata;
  logic        conv_clk_en;
  logic        channel_scan;
  logic [14:0] analog_pin_en;
  logic        port20_oe;
  logic        conv_end_irq;
  int          err_total = 0;
  int          comparisons = 0;
  int          n;
  logic [15:0] v;
  logic [15:0] flags;
  asc_row_s    rows [14];
  asc_ctrl dut (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .adc_sample    (adc_sample),
    .conv_clk_en   (conv_clk_en),
    .channel_scan  (channel_scan),
    .analog_pin_en (analog_pin_en),
    .port20_oe     (port20_oe),
    .conv_end_irq  (conv_end_irq)
  );
  assign flags = {12'h000, channel_scan, conv_clk_en, port20_oe, conv_end_irq};
  always #2 sys_clk = ~sys_clk;
  task automatic conclude();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wirq(input int lim, output int k);
    k = 0;
    while (conv_end_irq !== 1'b1 && k < lim)
    begin
      @(posedge sys_clk);
      #1 k++;
    end
  endtask
  task automatic need_irq();
    wirq(400, n);
    if (n >= 400)
    begin
      err_total++;
      $display("BAD t=%0t no end interrupt", $time);
      conclude();
    end
  endtask
  initial
  begin
    rows = '{
      '{`ASC_OFS_PINSEL, 16'h0002, 16'h0002, 15'h0001, 3'h0},
      '{`ASC_OFS_PINSEL, 16'h0003, 16'h0003, 15'h0003, 3'h0},
      '{`ASC_OFS_PINSEL, 16'h0009, 16'h0003, 15'h0003, 3'h0},
      '{`ASC_OFS_PINSEL, 16'h0001, 16'h0001, 15'h0000, 3'h0},
      '{`ASC_OFS_PINSEL, 16'h0000, 16'h0000, 15'h7FFF, 3'h0},
      '{`ASC_OFS_DIR, 16'h00FE, 16'h00FE, 15'h7FFF, 3'h1},
      '{`ASC_OFS_DIR, 16'h00FF, 16'h00FF, 15'h7FFF, 3'h0},
      '{`ASC_OFS_PENABLE, 16'h0020, 16'h0020, 15'h7FFF, 3'h2},
      '{`ASC_OFS_PENABLE, 16'h00DF, 16'h00DF, 15'h7FFF, 3'h0},
      '{`ASC_OFS_MODE0, 16'h0040, 16'h0040, 15'h7FFF, 3'h4},
      '{`ASC_OFS_MODE0, 16'h0000, 16'h0000, 15'h7FFF, 3'h0},
      '{`ASC_OFS_MODE1, 16'h00FF, 16'h00E3, 15'h7FFF, 3'h0},
      '{`ASC_OFS_RESULT, 16'h1234, 16'h0000, 15'h7FFF, 3'h0},
      '{`ASC_OFS_MASK, 16'h0001, 16'h0001, 15'h7FFF, 3'h0}};
    repeat (6) @(posedge sys_clk);
    chk(flags, 16'h0000);
    chk({1'b0, analog_pin_en}, 16'h7FFF);
    resetn <= 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v, rows[i].r);
      chk({1'b0, analog_pin_en}, {1'b0, rows[i].pin});
      chk({13'h0000, flags[3:1]}, {13'h0000, rows[i].ctl});
    end
    // Blocked starts: clock gate off, comparator off, hardware trigger
    for (int i = 0; i < 3; i++)
    begin
      wr(`ASC_OFS_PENABLE, (i == 0) ? 16'h0000 : 16'h0020);
      wr(`ASC_OFS_MODE1, (i == 2) ? 16'h00A0 : 16'h0020);
      wr(`ASC_OFS_MODE0, (i == 1) ? 16'h0080 : 16'h0081);
      wirq(300, n);
      chk(16'(n), 16'h012C);
      wr(`ASC_OFS_MODE0, 16'h0000);
    end
    // One-shot conversion with end interrupt enabled
    wr(`ASC_OFS_MODE1, 16'h0020);
    wr(`ASC_OFS_MODE0, 16'h0081);
    need_irq();
    chk(16'(n >= 249 && n <= 253), 16'h0001);
    rd(`ASC_OFS_RESULT, v);
    chk(v, 16'hAAC0);
    rd(`ASC_OFS_MODE0, v);
    chk(v, 16'h0001);
    rd(`ASC_OFS_STATUS, v);
    chk(v, 16'h0001);
    chk(16'(conv_end_irq), 16'h0000);
    // Masked end: status sticky, interrupt follows the mask
    wr(`ASC_OFS_MASK, 16'h0000);
    wr(`ASC_OFS_MODE0, 16'h0081);
    wirq(300, n);
    chk(16'(n), 16'h012C);
    wr(`ASC_OFS_MASK, 16'h0001);
    #1 chk(16'(conv_end_irq), 16'h0001);
    rd(`ASC_OFS_STATUS, v);
    chk(v, 16'h0001);
    // Sequential: repeats until the start bit is cleared
    wr(`ASC_OFS_MODE1, 16'h0000);
    wr(`ASC_OFS_MODE0, 16'h0081);
    need_irq();
    rd(`ASC_OFS_STATUS, v);
    chk(v, 16'h0001);
    @(posedge sys_clk);
    adc_sample <= 10'h3FF;
    need_irq();
    rd(`ASC_OFS_RESULT, v);
    chk(v, 16'hFFC0);
    wr(`ASC_OFS_MODE0, 16'h0001);
    rd(`ASC_OFS_STATUS, v);
    chk(v, 16'h0001);
    wirq(300, n);
    chk(16'(n), 16'h012C);
    // Mid-run reset returns registers and outputs to reset values
    wr(`ASC_OFS_DIR, 16'h00FE);
    wr(`ASC_OFS_PINSEL, 16'h0002);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    chk(flags, 16'h0000);
    chk({1'b0, analog_pin_en}, 16'h7FFF);
    resetn <= 1'b1;
    rd(`ASC_OFS_DIR, v);
    chk(v, 16'h00FF);
    rd(`ASC_OFS_MODE0, v);
    chk(v, 16'h0000);
    conclude();
  end
endmodule
